// [bench/scap_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module scap_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiDin,
  input wire logic spiDout,
  input wire logic alertEnable,
  input wire logic tamperIn,
  input wire logic [13:0] doneEvents,
  input wire flow_cmd_pkg::measRes_s measRes,
  input wire logic alertN,
  input wire logic tamperLatch,
  input wire flow_cmd_pkg::flightPins_s flightPins,
  input wire logic measBusy,
  input wire logic measStart,
  input wire logic cmdStart,
  input wire logic [7:0] cmdCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // alert pin follows enable and status flags
  property p_alert_off;
    !alertEnable |=> alertN;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert while disabled");
  property p_alert_set;
    alertEnable && |doneEvents |=> !alertN;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("event without alert");
  // only a status read, a disable or a reset command may release it
  property p_alert_hold;
    $rose(alertN) |-> !$past(alertEnable) || !$past(spiCsN) || cmdStart || $past(cmdStart);
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped early");
  property p_tamper;
    $rose(tamperIn) |-> ##[1:5] tamperLatch && (!alertN || !alertEnable);
  endproperty
  a_tamper: assert property (p_tamper) else $error("tamper not latched");
  property p_start_pins;
    measStart |-> cmdStart && measBusy && flightPins == (cmdCode == flow_cmd_pkg::OP_UP ? 6'h31 : 6'h0e);
  endproperty
  a_start_pins: assert property (p_start_pins) else $error("wrong launch pins");
  // execution waits for deselect and is a single pulse
  property p_exec_cs;
    cmdStart |-> spiCsN && $past(spiCsN, 2) ##1 !cmdStart;
  endproperty
  a_exec_cs: assert property (p_exec_cs) else $error("exec inside frame");
  property p_done_flag;
    measRes.done && measBusy && alertEnable |-> ##[1:2] !alertN && flightPins == 6'h00;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("no flag after flight");
  property p_dout_idle;
    spiCsN && $past(spiCsN, 4) |-> !spiDout;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout busy outside frame");
  property p_codes;
    cmdStart |-> cmdCode inside {[8'h00 : 8'h04], [8'h06 : 8'h0a], 8'h0e};
  endproperty
  a_codes: assert property (p_codes) else $error("unknown code executed");
endmodule
bind serial_command_and_alert_port scap_monitor mon (.*);
`default_nettype wire

// [bench/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic core_clk,
  input wire logic spiDout,
  output logic spiCsN,
  output logic spiSck,
  output logic spiDin,
  output logic rdValid,
  output logic [15:0] rdWord
);
  logic [15:0] wq[$];
  initial begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiDin = 1'b0;
    rdValid = 1'b0;
    rdWord = 16'h0000;
  end
  // one frame; dout is taken just before the next rise so sync delays never bite
  task automatic frame(input logic [7:0] op, input int nw);
    logic [15:0] sh;
    logic [15:0] ws;
    int n;
    n = 8 + 16 * nw;
    sh = 16'h0000;
    ws = 16'h0000;
    spiCsN <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i <= n; i++) begin
      if (i > 8) begin
        sh = {sh[14:0], spiDout};
        if ((i - 8) % 16 == 0 && op[7]) begin
          rdWord <= sh;
          rdValid <= 1'b1;
        end
      end
      if (i < n) begin
        if (i >= 8 && (i - 8) % 16 == 0) begin
          ws = wq.size() > 0 ? wq.pop_front() : 16'h0000;
        end
        spiDin <= i < 8 ? op[7 - i] : ws[15 - (i - 8) % 16];
        spiSck <= 1'b1;
        @(posedge core_clk);
        rdValid <= 1'b0;
        repeat (3) @(posedge core_clk);
        spiSck <= 1'b0;
        repeat (4) @(posedge core_clk);
      end
    end
    spiCsN <= 1'b1;
    // released line shows no stale bit
    spiDin <= ~spiDin;
    @(posedge core_clk);
    rdValid <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic alertEnable = 1'b0;
  logic tamperIn = 1'b0;
  logic [13:0] doneEvents = 14'h0000;
  flow_cmd_pkg::measRes_s measRes = '0;
  flow_cmd_pkg::flightPins_s flightPins;
  logic spiCsN, spiSck, spiDin, spiDout, alertN, tamperLatch, measBusy, measStart, cmdStart, rdValid;
  logic [7:0] cmdCode;
  logic [15:0] rdWord;
  logic [15:0] expQ[$];
  logic [15:0] expWord;
  logic [15:0] res[4];
  logic [13:0] ev;
  logic [7:0] ops[9] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e};
  logic [7:0] wb[2] = '{8'h17, 8'h43};
  int n_fail = 0;
  int num_checks = 0;
  integer seed = 32'hb1ef5489;
  always #20 core_clk = ~core_clk;
  serial_command_and_alert_port uut (.core_clk(core_clk), .rst(rst), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiDin(spiDin), .spiDout(spiDout), .alertEnable(alertEnable), .tamperIn(tamperIn),
    .doneEvents(doneEvents), .measRes(measRes), .alertN(alertN), .tamperLatch(tamperLatch),
    .flightPins(flightPins), .measBusy(measBusy), .measStart(measStart), .cmdStart(cmdStart),
    .cmdCode(cmdCode));
  spi_host_model host (.core_clk(core_clk), .spiDout(spiDout), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiDin(spiDin), .rdValid(rdValid), .rdWord(rdWord));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [13:0] e);
    doneEvents <= e;
    @(posedge core_clk);
    doneEvents <= 14'h0000;
    @(posedge core_clk);
  endtask
  task automatic rd_status(input logic [15:0] exp);
    expQ.push_back(exp);
    host.frame(8'hfe, 1);
  endtask
  // each command pulse or read word meets the oldest note; empty queue gives x
  always @(posedge core_clk) begin
    if (cmdStart || rdValid) begin
      expWord = expQ.size() > 0 ? expQ.pop_front() : 16'hxxxx;
      check(cmdStart ? {8'h00, cmdCode} : rdWord, expWord);
      if (cmdStart) begin
        check(16'(measStart), 16'(expWord < 16'h0002));
      end
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    cyc(4);
    check({alertN, tamperLatch, measBusy}, 3'b100);
    alertEnable <= 1'b1;
    ev = 14'($random(seed)) | 14'h0001;
    pulse(ev);
    check(alertN, 1'b0);
    rd_status({2'b00, ev});
    check(alertN, 1'b1);
    rd_status(16'h0000);
    $display("end events");
    pulse(14'h0001);
    expQ.push_back(16'h0001);
    fork
      host.frame(8'hfe, 1);
      begin
        cyc(100);
        pulse(14'h2000);
      end
    join
    check(alertN, 1'b0);
    rd_status(16'h2000);
    $display("end read race");
    alertEnable <= 1'b0;
    pulse(ev);
    cyc(2);
    check(alertN, 1'b1);
    alertEnable <= 1'b1;
    cyc(2);
    check(alertN, 1'b0);
    rd_status({2'b00, ev});
    tamperIn <= 1'b1;
    cyc(6);
    check({tamperLatch, alertN}, 2'b10);
    rd_status(16'h4000);
    check(tamperLatch, 1'b1);
    $display("end alert gate and tamper");
    for (int d = 0; d < 2; d++) begin
      expQ.push_back(16'(d));
      host.frame(8'(d), 0);
      check({measBusy, flightPins}, d ? 7'h4e : 7'h71);
      for (int k = 0; k < 4; k++) begin
        res[k] = 16'($random(seed));
        measRes <= '{1'b1, 4'(k), res[k], 1'b0};
        @(posedge core_clk);
      end
      measRes <= '{1'b0, 4'h0, 16'h0000, 1'b1};
      @(posedge core_clk);
      measRes <= '0;
      cyc(3);
      check({measBusy, alertN}, 2'b00);
      foreach (res[k]) expQ.push_back(res[k]);
      host.frame(d ? 8'hd4 : 8'hc4, 4);
      rd_status(16'h8000);
    end
    $display("end flights");
    foreach (wb[i]) begin
      res[0] = 16'($random(seed));
      res[1] = 16'($random(seed));
      host.wq.push_back(res[0]);
      host.wq.push_back(res[1]);
      host.frame(wb[i], 2);
      expQ.push_back(res[0]);
      host.frame(wb[i] | 8'h80, 1);
      expQ.push_back(res[1]);
      host.frame(8'hb0, 1);
    end
    $display("end register access");
    host.frame(8'h05, 0);
    host.frame(8'h10, 0);
    check(alertN, 1'b1);
    rd_status(16'h0000);
    foreach (ops[i]) begin
      expQ.push_back({8'h00, ops[i]});
      host.frame(ops[i], 0);
    end
    check(tamperLatch, 1'b0);
    check(16'(expQ.size()), 16'h0000);
    $display("end opcodes");
    test_done();
  end
  // watchdog far beyond the expected run length
  initial begin
    #3000000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire

// [rtl/flow_cmd_pkg.sv]
package flow_cmd_pkg;

  // execution opcodes
  localparam logic [7:0] OP_UP = 8'h00;
  localparam logic [7:0] OP_DOWN = 8'h01;
  localparam logic [7:0] OP_DIFF = 8'h02;
  localparam logic [7:0] OP_TEMP = 8'h03;
  localparam logic [7:0] OP_RESET = 8'h04;
  localparam logic [7:0] OP_BANDPASS = 8'h06;
  localparam logic [7:0] OP_EVENT1 = 8'h07;
  localparam logic [7:0] OP_EVENT3 = 8'h09;
  localparam logic [7:0] OP_HALT = 8'h0a;
  localparam logic [7:0] OP_CAL = 8'h0e;

  // register opcode ranges
  localparam logic [7:0] RD_LO_A = 8'h94;
  localparam logic [7:0] RD_HI_A = 8'h97;
  localparam logic [7:0] RD_LO_B = 8'hb0;
  localparam logic [7:0] WR_LO_A = 8'h14;
  localparam logic [7:0] WR_HI_A = 8'h17;
  localparam logic [7:0] WR_LO_B = 8'h30;
  localparam logic [7:0] WR_HI_B = 8'h43;

  // register addresses inside the 7-bit map
  localparam logic [6:0] MAP_START = 7'h30;
  localparam logic [6:0] MAP_LAST = 7'h7f;
  localparam logic [6:0] STATUS_ADDR = 7'h7e;
  localparam logic [6:0] UP_RES_BASE = 7'h44;
  localparam logic [6:0] DOWN_RES_BASE = 7'h54;
  localparam int MEM_DEPTH = 128;

  // status layout and counts
  localparam int FLIGHT_BIT = 15;
  localparam int TAMPER_BIT = 14;
  localparam int EXT_W = 14;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [4:0] OP_LAST_BIT = 5'h07;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0f;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_OPCODE = 3'b001,
    P_RDDATA = 3'b010,
    P_WRDATA = 3'b011,
    P_EXEC = 3'b100,
    P_IGNORE = 3'b101
  } phase_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_UP = 2'b01,
    M_DOWN = 2'b10
  } meas_e;

  // result words streamed from the time converter
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [15:0] data;
    logic done;
  } measRes_s;

  // launcher and receiver selection
  typedef struct packed {
    logic upstreamPosPin;
    logic upstreamNegPin;
    logic downstreamPosPin;
    logic downstreamNegPin;
    logic rxOnUpstream;
    logic rxOnDownstream;
  } flightPins_s;

endpackage

// [rtl/flow_result_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module flow_result_mem (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [6:0] raddr,
  output logic [15:0] rdata
);

  typedef struct packed {
    logic [15:0] rdata;
  } state_s;

  state_s q;
  state_s d;
  logic [15:0] mem [0:flow_cmd_pkg::MEM_DEPTH-1];

  // read data is registered, one cycle behind the address
  always_comb begin
    d = q;
    d.rdata = mem[raddr];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // array itself has no reset
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = q.rdata;

endmodule
`default_nettype wire

// [rtl/serial_command_and_alert_port.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_command_and_alert_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiDin,
  output logic spiDout,
  input wire logic alertEnable,
  input wire logic tamperIn,
  input wire logic [13:0] doneEvents,
  input wire flow_cmd_pkg::measRes_s measRes,
  output logic alertN,
  output logic tamperLatch,
  output flow_cmd_pkg::flightPins_s flightPins,
  output logic measBusy,
  output logic measStart,
  output logic cmdStart,
  output logic [7:0] cmdCode
);

  typedef struct packed {
    logic [2:0] csSync;
    logic [2:0] sckSync;
    logic [1:0] dinSync;
    logic [2:0] tamSync;
    flow_cmd_pkg::phase_e phase;
    logic [4:0] bitCnt;
    logic [15:0] rxShift;
    logic [7:0] opcode;
    logic [6:0] addr;
    logic [15:0] txShift;
    logic dout;
    logic [1:0] rdPend;
    logic wrPend;
    logic [6:0] wrAddr;
    logic [15:0] wrData;
    logic [15:0] status;
    logic tamperLatch;
    logic alertN;
    flow_cmd_pkg::meas_e meas;
    logic measBusy;
    flow_cmd_pkg::flightPins_s pins;
    logic measStart;
    logic cmdStart;
    logic [7:0] cmdCode;
  } state_s;

  localparam state_s STATE_RST = '{
    csSync: 3'h7,
    alertN: 1'b1,
    status: flow_cmd_pkg::STATUS_RST,
    phase: flow_cmd_pkg::P_IDLE,
    meas: flow_cmd_pkg::M_IDLE,
    default: '0
  };

  state_s q;
  state_s d;

  logic memWe;
  logic [6:0] memWaddr;
  logic [15:0] memWdata;
  logic [15:0] memRdata;

  logic csLow;
  logic csFall;
  logic csRise;
  logic sckFall;
  logic sckRise;
  logic tamperEv;
  logic startExec;
  logic [15:0] rxNext;
  logic [15:0] newEv;
  logic [15:0] clrMask;

  // opcode classes
  function automatic logic isRead(input logic [7:0] op);
    isRead = (op >= flow_cmd_pkg::RD_LO_A && op <= flow_cmd_pkg::RD_HI_A)
      || (op >= flow_cmd_pkg::RD_LO_B);
  endfunction

  function automatic logic isWrite(input logic [7:0] op);
    isWrite = (op >= flow_cmd_pkg::WR_LO_A && op <= flow_cmd_pkg::WR_HI_A)
      || (op >= flow_cmd_pkg::WR_LO_B && op <= flow_cmd_pkg::WR_HI_B);
  endfunction

  function automatic logic isExec(input logic [7:0] op);
    isExec = (op <= flow_cmd_pkg::OP_RESET)
      || (op >= flow_cmd_pkg::OP_BANDPASS && op <= flow_cmd_pkg::OP_HALT)
      || (op == flow_cmd_pkg::OP_CAL);
  endfunction

  // read pointer walks to the end, then restarts at map start
  function automatic logic [6:0] nextRead(input logic [6:0] a);
    if (a == flow_cmd_pkg::MAP_LAST) begin
      nextRead = flow_cmd_pkg::MAP_START;
    end else begin
      nextRead = 7'(a + 7'h01);
    end
  endfunction

  // write pointer wraps after the last writable word
  function automatic logic [6:0] nextWrite(input logic [6:0] a);
    if (a == flow_cmd_pkg::WR_HI_B[6:0]) begin
      nextWrite = flow_cmd_pkg::MAP_START;
    end else if (a == flow_cmd_pkg::WR_HI_A[6:0]) begin
      nextWrite = flow_cmd_pkg::MAP_START;
    end else begin
      nextWrite = 7'(a + 7'h01);
    end
  endfunction

  // edge finding on synchronised pins; first stages feed only the second
  assign csLow = ~q.csSync[1];
  assign csFall = q.csSync[2] & ~q.csSync[1];
  assign csRise = ~q.csSync[2] & q.csSync[1];
  assign sckFall = q.sckSync[2] & ~q.sckSync[1];
  assign sckRise = ~q.sckSync[2] & q.sckSync[1];
  assign tamperEv = q.tamSync[1] & ~q.tamSync[2];
  assign rxNext = {q.rxShift[14:0], q.dinSync[1]};

  always_comb begin
    d = q;
    memWe = 1'b0;
    memWaddr = q.wrAddr;
    memWdata = q.wrData;
    newEv = '0;
    clrMask = '0;
    startExec = 1'b0;

    // pins cross into the core clock through two flops
    d.csSync = {q.csSync[1:0], spiCsN};
    d.sckSync = {q.sckSync[1:0], spiSck};
    d.dinSync = {q.dinSync[0], spiDin};
    d.tamSync = {q.tamSync[1:0], tamperIn};
    d.measStart = 1'b0;
    d.cmdStart = 1'b0;
    d.rdPend = {q.rdPend[0], 1'b0};

    // result words land before the done flag
    if (measRes.valid && q.meas != flow_cmd_pkg::M_IDLE) begin
      memWe = 1'b1;
      memWdata = measRes.data;
      if (q.meas == flow_cmd_pkg::M_UP) begin
        memWaddr = 7'(flow_cmd_pkg::UP_RES_BASE + {3'h0, measRes.index});
      end else begin
        memWaddr = 7'(flow_cmd_pkg::DOWN_RES_BASE + {3'h0, measRes.index});
      end
    end else if (q.wrPend) begin
      // host write waits for as long as results hold the port
      memWe = 1'b1;
      d.wrPend = 1'b0;
    end

    if (measRes.done && q.meas != flow_cmd_pkg::M_IDLE) begin
      newEv[flow_cmd_pkg::FLIGHT_BIT] = 1'b1;
      d.meas = flow_cmd_pkg::M_IDLE;
      d.pins = '0;
    end

    if (tamperEv) begin
      d.tamperLatch = 1'b1;
      newEv[flow_cmd_pkg::TAMPER_BIT] = 1'b1;
    end

    newEv[flow_cmd_pkg::EXT_W-1:0] = doneEvents;

    // frame edges start and end the transfer
    if (csFall) begin
      d.phase = flow_cmd_pkg::P_OPCODE;
      d.bitCnt = '0;
      d.dout = 1'b0;
    end else if (csRise) begin
      if (q.phase == flow_cmd_pkg::P_EXEC && q.bitCnt == 5'h00) begin
        startExec = 1'b1;
      end
      d.phase = flow_cmd_pkg::P_IDLE;
      d.dout = 1'b0;
    end else if (csLow && sckFall) begin
      case (q.phase)
        flow_cmd_pkg::P_OPCODE: begin
          d.rxShift = rxNext;
          d.bitCnt = 5'(q.bitCnt + 5'h01);
          if (q.bitCnt == flow_cmd_pkg::OP_LAST_BIT) begin
            d.bitCnt = '0;
            d.opcode = rxNext[7:0];
            if (isRead(rxNext[7:0])) begin
              d.phase = flow_cmd_pkg::P_RDDATA;
              d.addr = rxNext[6:0];
              d.rdPend[0] = 1'b1;
            end else if (isWrite(rxNext[7:0])) begin
              d.phase = flow_cmd_pkg::P_WRDATA;
              d.addr = rxNext[6:0];
            end else if (isExec(rxNext[7:0])) begin
              d.phase = flow_cmd_pkg::P_EXEC;
            end else begin
              // unknown opcode, rest of frame ignored
              d.phase = flow_cmd_pkg::P_IGNORE;
            end
          end
        end
        flow_cmd_pkg::P_RDDATA: begin
          d.bitCnt = 5'(q.bitCnt + 5'h01);
          // next word fetched after sixteen bits
          if (q.bitCnt == flow_cmd_pkg::WORD_LAST_BIT) begin
            d.bitCnt = '0;
            d.addr = nextRead(q.addr);
            d.rdPend[0] = 1'b1;
          end
        end
        flow_cmd_pkg::P_WRDATA: begin
          d.rxShift = rxNext;
          d.bitCnt = 5'(q.bitCnt + 5'h01);
          if (q.bitCnt == flow_cmd_pkg::WORD_LAST_BIT) begin
            d.bitCnt = '0;
            // store then step, wrapping to map start
            d.wrAddr = q.addr;
            d.wrData = rxNext;
            d.wrPend = isWrite({1'b0, q.addr});
            d.addr = nextWrite(q.addr);
          end
        end
        flow_cmd_pkg::P_EXEC: begin
          // clocks past the opcode spoil the command
          d.bitCnt = 5'h01;
        end
        default: begin
          d.bitCnt = q.bitCnt;
        end
      endcase
    end else if (csLow && sckRise && q.phase == flow_cmd_pkg::P_RDDATA) begin
      // data bit advances on rising edge
      d.dout = q.txShift[15];
      d.txShift = {q.txShift[14:0], 1'b0};
    end

    // status word capture clears exactly what it read; other words clear nothing
    if (q.rdPend[1]) begin
      // status words come from the live flags, not the store
      if (q.addr == flow_cmd_pkg::STATUS_ADDR) begin
        d.txShift = q.status;
        clrMask = q.status;
      end else begin
        d.txShift = memRdata;
      end
    end

    // command launch once the frame closes
    if (startExec) begin
      d.cmdStart = 1'b1;
      d.cmdCode = q.opcode;
      case (q.opcode)
        flow_cmd_pkg::OP_UP: begin
          if (q.meas == flow_cmd_pkg::M_IDLE) begin
            d.meas = flow_cmd_pkg::M_UP;
            d.measStart = 1'b1;
            d.pins = '0;
            d.pins.upstreamPosPin = 1'b1;
            d.pins.upstreamNegPin = 1'b1;
            d.pins.rxOnDownstream = 1'b1;
          end
        end
        flow_cmd_pkg::OP_DOWN: begin
          if (q.meas == flow_cmd_pkg::M_IDLE) begin
            d.meas = flow_cmd_pkg::M_DOWN;
            d.measStart = 1'b1;
            d.pins = '0;
            d.pins.downstreamPosPin = 1'b1;
            d.pins.downstreamNegPin = 1'b1;
            d.pins.rxOnUpstream = 1'b1;
          end
        end
        flow_cmd_pkg::OP_RESET: begin
          // soft reset wipes flags and abandons a measurement
          d.status = flow_cmd_pkg::STATUS_RST;
          // a tamper edge in this same cycle still wins
          d.tamperLatch = tamperEv;
          d.meas = flow_cmd_pkg::M_IDLE;
          d.pins = '0;
        end
        default: begin
          // remaining commands run in the outside sequencers
          d.meas = d.meas;
        end
      endcase
    end

    // a set in the read cycle beats the clear
    d.status = (d.status & ~clrMask) | newEv;

    // alert follows status, gated by enable
    d.alertN = ~(alertEnable & (|d.status));

    // busy kept in a flop so the pin needs no decode
    d.measBusy = (d.meas != flow_cmd_pkg::M_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // result and register store, read port tracks the pointer
  flow_result_mem resultMem (
    .core_clk(core_clk),
    .rst(rst),
    .we(memWe),
    .waddr(memWaddr),
    .wdata(memWdata),
    .raddr(q.addr),
    .rdata(memRdata)
  );

  // every output is a flop of the state
  assign spiDout = q.dout;
  assign alertN = q.alertN;
  assign tamperLatch = q.tamperLatch;
  assign flightPins = q.pins;
  assign measStart = q.measStart;
  assign cmdStart = q.cmdStart;
  assign cmdCode = q.cmdCode;
  assign measBusy = q.measBusy;

endmodule
`default_nettype wire
